// >>> hw/act_pkg.sv
/*
 * constants, register indices and the control field layout of the
 * asynchronous 16-bit counter/timer.
 * assumes an axi4-lite master that places register index n at byte 4*n.
 */
// What this block does
// - sync_bypass set with clock_source_select counts the selected pin as unsynchronised, still through the pin synchronisers
// - unsynchronised counting continues in sleep; overflow raises a waking interrupt
// - unsynchronised counting never feeds compare matches or their trigger
// - counter byte reads always return a clean, settled byte
// - osc_enable turns on the low-power oscillator, which keeps running in sleep
// - compare mode 1011 special event trigger clears the counter
// - a counter write coinciding with a trigger clear keeps the written value
// - with trigger clear the compare value pair acts as the period
// - counter bytes survive every reset; only the trigger clears them
// - power-on reset zeroes counter_control; other resets leave it
// - writing either counter byte clears the prescaler
// - the count shows as separate low and high byte registers
// - counter mode counts rising edges of the selected oscillator or clock pin
package act_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_GLOBAL   = 8'h0B;
  localparam logic [7:0] IDX_FLAGS    = 8'h0C;
  localparam logic [7:0] IDX_CNT_LO   = 8'h0E;
  localparam logic [7:0] IDX_CNT_HI   = 8'h0F;
  localparam logic [7:0] IDX_CONTROL  = 8'h10;
  localparam logic [7:0] IDX_ENABLES  = 8'h8C;
  localparam logic [7:0] IDX_CMP_LO   = 8'h20;
  localparam logic [7:0] IDX_CMP_HI   = 8'h21;
  localparam logic [7:0] IDX_CMP_MODE = 8'h22;

  // field positions and implemented-bit masks
  localparam int         BIT_OVF      = 0;
  localparam int         BIT_CMP      = 2;
  localparam int         BIT_IRQ_ALL    = 7;
  localparam int         BIT_IRQ_PERIPH = 6;
  localparam logic [7:0] FLAG_MASK    = 8'h05;
  localparam logic [7:0] GLOBAL_MASK  = 8'hC0;
  localparam logic [7:0] CONTROL_MASK = 8'h3F;

  // reset values
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [7:0] RST_FLAGS    = 8'h00;
  localparam logic [3:0] RST_CMP_MODE = 4'h0;
  localparam logic [15:0] CNT_CLEAR   = 16'h0000;
  localparam logic [15:0] CNT_TOP     = 16'hFFFF;

  // compare mode codes
  localparam logic [3:0] CMP_SPECIAL  = 4'hB;
  localparam logic [1:0] CMP_GROUP    = 2'h2;

  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] prescale_select;
    logic       osc_enable;
    logic       sync_bypass;
    logic       clock_source_select;
    logic       run_enable;
  } act_ctl_type;

endpackage : act_pkg

// >>> hw/act_timer_top.sv
/*
 * 16-bit counter/timer with prescaler, compare unit trigger clear and an
 * axi4-lite register slave.
 * assumes clk is the instruction clock, sleep_mode comes from the same
 * domain and the two clock pins are asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none
module act_timer_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              other_rst,
  input  wire logic              sleep_mode,
  input  wire logic              osc_in_pin,
  input  wire logic              ext_clock_pin,
  output logic                   osc_amp_on,
  output logic                   irq,
  output logic                   wake_req,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  if (ADDR_W < 12) begin : g_bad_addr
    $error("act_timer_top: ADDR_W must be at least 12");
  end

  act_pkg::act_ctl_type ctl;
  logic [7:0]        global_ctl;
  logic [7:0]        flags;
  logic [7:0]        enables;
  logic [15:0]       count;
  logic [15:0]       cmp_val;
  logic [3:0]        cmp_mode;
  logic [2:0]        pre_cnt;
  logic              osc_s1, osc_s2, ext_s1, ext_s2, pin_prev;
  logic              match_q;
  logic              aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;

  wire soft_rst = rst | other_rst;

  // pin synchronisers; first stages feed only the second stages
  always_ff @(posedge clk) begin
    osc_s1   <= osc_in_pin;
    osc_s2   <= osc_s1;
    ext_s1   <= ext_clock_pin;
    ext_s2   <= ext_s1;
  end

  // pin choice and edge detect
  wire pin_sel  = ctl.osc_enable ? osc_s2 : ext_s2;
  wire pin_rise = pin_sel & ~pin_prev;

  // last level of the chosen pin; no reset, it simply follows the pin
  always_ff @(posedge clk) begin
    pin_prev <= pin_sel;
  end
  assign osc_amp_on = ctl.osc_enable;

  // mode decode; async counting keeps going while asleep
  wire cs       = ctl.clock_source_select;
  wire async_m  = cs & ctl.sync_bypass;
  wire tick_src = cs ? pin_rise : 1'b1;
  wire pre_go   = ctl.run_enable & tick_src & ~(sleep_mode & ~cs);
  wire [2:0] ps_mask = {ctl.prescale_select == 2'h3,
                        ctl.prescale_select[1],
                        |ctl.prescale_select};
  wire pre_hit  = (pre_cnt & ps_mask) == ps_mask;
  // sync path is off in sleep, only the unsynchronised path advances
  wire inc      = pre_go & pre_hit & ~(sleep_mode & cs & ~ctl.sync_bypass);

  // bus write decode
  wire [ADDR_W-3:0] w_idx = aw_addr_q[ADDR_W-1:2];
  wire w_hi0   = ~|w_idx[ADDR_W-3:8];
  wire do_wr   = aw_held & w_held & ~s_axi_bvalid;
  wire wr_en   = do_wr & w_strb_q[0];
  wire [7:0] wb = w_data_q[7:0];
  wire wr_glob = wr_en & w_hi0 & (w_idx[7:0] == act_pkg::IDX_GLOBAL);
  wire wr_flag = wr_en & w_hi0 & (w_idx[7:0] == act_pkg::IDX_FLAGS);
  wire wr_lo   = wr_en & w_hi0 & (w_idx[7:0] == act_pkg::IDX_CNT_LO);
  wire wr_hi   = wr_en & w_hi0 & (w_idx[7:0] == act_pkg::IDX_CNT_HI);
  wire wr_ctl  = wr_en & w_hi0 & (w_idx[7:0] == act_pkg::IDX_CONTROL);
  wire wr_ena  = wr_en & w_hi0 & (w_idx[7:0] == act_pkg::IDX_ENABLES);
  wire wr_cl   = wr_en & w_hi0 & (w_idx[7:0] == act_pkg::IDX_CMP_LO);
  wire wr_ch   = wr_en & w_hi0 & (w_idx[7:0] == act_pkg::IDX_CMP_HI);
  wire wr_cm   = wr_en & w_hi0 & (w_idx[7:0] == act_pkg::IDX_CMP_MODE);
  wire wr_any  = wr_lo | wr_hi;
  wire w_map   = w_hi0 & (wr_map(w_idx[7:0]));

  function automatic logic wr_map(input logic [7:0] i);
    wr_map = (i == act_pkg::IDX_GLOBAL) | (i == act_pkg::IDX_FLAGS)
           | (i == act_pkg::IDX_CNT_LO) | (i == act_pkg::IDX_CNT_HI)
           | (i == act_pkg::IDX_CONTROL) | (i == act_pkg::IDX_ENABLES)
           | (i == act_pkg::IDX_CMP_LO) | (i == act_pkg::IDX_CMP_HI)
           | (i == act_pkg::IDX_CMP_MODE);
  endfunction : wr_map

  // compare unit; async counting is no time base for it
  wire at_match  = count == cmp_val;
  wire cmp_on    = (cmp_mode[3:2] == act_pkg::CMP_GROUP) & ~async_m;
  wire cmp_ev    = cmp_on & at_match & ~match_q;
  wire trig      = cmp_ev & (cmp_mode == act_pkg::CMP_SPECIAL);
  // trigger clear never counts as an overflow
  wire ovf_ev    = inc & (count == act_pkg::CNT_TOP) & ~trig & ~wr_any;

  // next count; a write beats the trigger clear
  wire [15:0] cnt_inc = count + 16'h0001;
  wire [15:0] next_count =
      wr_lo ? {count[15:8], wb} :
      wr_hi ? {wb, count[7:0]} :
      trig  ? act_pkg::CNT_CLEAR :
      inc   ? cnt_inc : count;

  // counter has no reset term so it survives every reset
  always_ff @(posedge clk) begin
    count <= next_count;
  end

  // prescaler, cleared by any counter byte write
  always_ff @(posedge clk) begin
    if (rst || wr_any) begin
      pre_cnt <= 3'h0;
    end else if (pre_go) begin
      pre_cnt <= pre_hit ? 3'h0 : pre_cnt + 3'h1;
    end
  end

  // match edge memory so one match fires once
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      match_q <= 1'b0;
    end else begin
      match_q <= at_match;
    end
  end

  // control register: only power-on reset clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl <= act_pkg::act_ctl_type'(act_pkg::RST_CONTROL);
    end else if (wr_ctl) begin
      ctl <= act_pkg::act_ctl_type'(wb & act_pkg::CONTROL_MASK);
    end
  end

  // sticky flags; a new event wins over a write-one clear
  wire [7:0] flag_set = {5'h00, cmp_ev, 1'b0, ovf_ev};
  wire [7:0] flag_clr = wr_flag ? wb : 8'h00;
  wire [7:0] next_flags = ((flags & ~flag_clr) | flag_set) & act_pkg::FLAG_MASK;

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      flags <= act_pkg::RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  // interrupt side registers
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      enables    <= act_pkg::RST_FLAGS;
      global_ctl <= act_pkg::RST_FLAGS;
      cmp_mode   <= act_pkg::RST_CMP_MODE;
    end else begin
      if (wr_ena) enables <= wb & act_pkg::FLAG_MASK;
      if (wr_glob) global_ctl <= wb & act_pkg::GLOBAL_MASK;
      if (wr_cm) cmp_mode <= wb[3:0];
    end
  end

  // compare value pair returns to FFFF on either reset, unlike the counter
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      cmp_val <= act_pkg::CNT_TOP;
    end else begin
      if (wr_cl) cmp_val[7:0] <= wb;
      if (wr_ch) cmp_val[15:8] <= wb;
    end
  end

  // wake ignores the global gates, the interrupt line does not
  wire pend = |(flags & enables);
  assign wake_req = pend & sleep_mode;
  assign irq = pend & global_ctl[act_pkg::BIT_IRQ_ALL] & global_ctl[act_pkg::BIT_IRQ_PERIPH];

  // write channel holding; address and data taken in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_wr) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= act_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= w_map ? act_pkg::RESP_OKAY : act_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read decode; all state lives on clk so bytes are always settled
  wire [ADDR_W-3:0] r_idx = s_axi_araddr[ADDR_W-1:2];
  wire r_hi0 = ~|r_idx[ADDR_W-3:8];
  wire [7:0] ri = r_idx[7:0];
  wire r_map = r_hi0 & wr_map(ri);
  wire [7:0] rbyte =
      ~r_hi0                     ? 8'h00 :
      (ri == act_pkg::IDX_GLOBAL)  ? global_ctl :
      (ri == act_pkg::IDX_FLAGS)   ? flags :
      (ri == act_pkg::IDX_CNT_LO)  ? count[7:0] :
      (ri == act_pkg::IDX_CNT_HI)  ? count[15:8] :
      (ri == act_pkg::IDX_CONTROL) ? ctl :
      (ri == act_pkg::IDX_ENABLES) ? enables :
      (ri == act_pkg::IDX_CMP_LO)  ? cmp_val[7:0] :
      (ri == act_pkg::IDX_CMP_HI)  ? cmp_val[15:8] :
      (ri == act_pkg::IDX_CMP_MODE) ? {4'h0, cmp_mode} : 8'h00;

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= act_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rbyte};
      s_axi_rresp  <= r_map ? act_pkg::RESP_OKAY : act_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // check helper: count bytes are undefined until first written or cleared
  logic [1:0] cnt_seen;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_seen <= 2'b00;
    end else begin
      cnt_seen <= cnt_seen | {wr_hi | trig, wr_lo | trig};
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_write_wins: assert property (wr_lo && trig |=> count[7:0] == $past(wb))
    else $error("trigger clear beat a counter write");
  chk_trig_clear: assert property (trig && !wr_any |=> count == 16'h0000)
    else $error("trigger did not clear counter");
  chk_trig_no_ovf: assert property (trig && !flags[0] |=> !flags[0])
    else $error("trigger clear set overflow flag");
  chk_async_no_cmp: assert property (async_m && at_match |=> !flags[2] || $past(flags[2]))
    else $error("async count raised a compare");
  chk_async_sleep: assert property (sleep_mode && async_m && inc && !wr_any
                                    |=> count == $past(cnt_inc))
    else $error("async count stalled in sleep");
  chk_sync_sleep: assert property (sleep_mode && cs && !ctl.sync_bypass && !wr_any && !trig
                                   |=> $stable(count))
    else $error("sync count moved in sleep");
  chk_pre_clear: assert property (wr_any |=> pre_cnt == 3'h0)
    else $error("prescaler not cleared by write");
  chk_ovf_set: assert property (ovf_ev |=> flags[0] ##1 flags[0] || $past(wr_flag))
    else $error("overflow flag not set");
  chk_ctl_por: assert property (disable iff (1'b0) rst |=> ctl == 8'h00)
    else $error("control not cleared by power-on reset");
  chk_cnt_keep: assert property (disable iff (1'b0) soft_rst && cnt_seen == 2'b11
                                 && !inc && !wr_any && !trig |=> $stable(count))
    else $error("reset disturbed counter");
  chk_edge_count: assert property (cs && ctl.run_enable && pin_rise && pre_hit && !sleep_mode
                                   && cnt_seen == 2'b11 && !wr_any && !trig |=> count == $past(cnt_inc))
    else $error("pin edge not counted");
  chk_read_low: assert property (s_axi_arvalid && s_axi_arready && r_hi0 && ri == act_pkg::IDX_CNT_LO
                                 && cnt_seen[0] |=> s_axi_rdata[7:0] == $past(count[7:0]))
    else $error("low count byte read wrong");

  cov_trig:  cover property (trig ##1 count == 16'h0000);
  cov_ovf:   cover property (ovf_ev ##1 irq);
  cov_async: cover property (sleep_mode && async_m && inc ##1 wake_req);
  cov_async_match: cover property (async_m && at_match);
  cov_prescaled:   cover property (ctl.prescale_select != 2'h0 && inc);

endmodule : act_timer_top
`default_nettype wire

// >>> sim/act_clk_src.sv
/*
 * behavioural source for the timer's two clock pins.
 * assumes the bench asks for bursts of rising edges from the clk domain.
 */
`timescale 1ns/100ps
`default_nettype none
module act_clk_src (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [3:0] count,
  input  wire logic       use_osc,
  output logic            ext_clock_pin,
  output logic            osc_in_pin,
  output logic            busy
);
  logic [3:0] left;
  logic [1:0] phase;
  logic       level;
  // one pulse per 8 clk, slow enough for the two-flop sampler
  always_ff @(posedge clk) begin
    if (rst) begin
      left  <= 4'h0;
      phase <= 2'h0;
      level <= 1'b0;
    end else if (start) begin
      left  <= count;
      phase <= 2'h0;
    end else if (left != 4'h0) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        level <= ~level;
        if (level) left <= left - 4'h1;
      end
    end
  end
  // pins rest low between bursts: the clock stands still
  assign ext_clock_pin = level & ~use_osc;
  assign osc_in_pin    = level & use_osc;
  assign busy          = left != 4'h0;
endmodule : act_clk_src
`default_nettype wire

// >>> sim/tb.sv
/*
 * bench for act_timer_top: registers, counting modes, trigger clear, irq, resets.
 * assumes act_clk_src drives both clock pins.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        other_rst = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        osc_in_pin, ext_clock_pin, osc_amp_on, irq, wake_req;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        src_start = 1'b0, src_osc = 1'b0, src_busy;
  logic [3:0]  src_count = 4'h0;
  logic [7:0]  d, h, l;
  int          fails = 0, num_checks = 0, cycles = 0;

  act_timer_top dut (.clk, .rst, .other_rst, .sleep_mode, .osc_in_pin, .ext_clock_pin,
    .osc_amp_on, .irq, .wake_req, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  act_clk_src src (.clk, .rst, .start(src_start), .count(src_count), .use_osc(src_osc),
    .ext_clock_pin, .osc_in_pin, .busy(src_busy));

  // clock and hang guard
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // write: offer aw and w together, drop each when taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    @(posedge clk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // burst of n rising edges, then room for the pin sampler
  task automatic pulses(input logic [3:0] n, input logic osc);
    @(posedge clk);
    src_count <= n;
    src_osc <= osc;
    src_start <= 1'b1;
    @(posedge clk);
    src_start <= 1'b0;
    @(posedge clk);
    do @(posedge clk); while (src_busy);
    repeat (6) @(posedge clk);
  endtask : pulses

  task automatic t_reset_values;
    rd(8'h10); chk("control", 8'h00, d);
    rd(8'h0C); chk("flags", 8'h00, d);
    rd(8'h8C); chk("enables", 8'h00, d);
    rd(8'h30); chk("unmapped rresp", 2'h2, r);
    chk("unmapped rdata", 8'h00, d);
    wr(8'h30, 8'h55); chk("unmapped bresp", 2'h2, r);
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_overflow_irq;
    wr(8'h10, 8'h00);
    wr(8'h0F, 8'hFF);
    wr(8'h0E, 8'hF0);
    rd(8'h0F); chk("count high", 8'hFF, d);
    rd(8'h0E); chk("count low", 8'hF0, d);
    wr(8'h8C, 8'h01);
    wr(8'h0B, 8'hC0);
    wr(8'h10, 8'h01);
    repeat (40) @(posedge clk);
    wr(8'h10, 8'h00);
    rd(8'h0C); chk("overflow flag", 8'h01, d);
    chk("irq raised", 1'b1, irq);
    rd(8'h0F); chk("count high wrapped", 8'h00, d);
    wr(8'h8C, 8'h00); chk("irq masked", 1'b0, irq);
    wr(8'h8C, 8'h01); chk("irq unmasked", 1'b1, irq);
    chk("no wake awake", 1'b0, wake_req);
    wr(8'h0B, 8'h40); chk("irq global gate", 1'b0, irq);
    wr(8'h0B, 8'hC0);
    wr(8'h0C, 8'h01);
    rd(8'h0C); chk("flag cleared", 8'h00, d);
    chk("irq cleared", 1'b0, irq);
    $display("test overflow_irq done");
  endtask : t_overflow_irq

  task automatic t_compare_clear;
    wr(8'h22, 8'h0B);
    wr(8'h21, 8'h00);
    wr(8'h20, 8'h10);
    wr(8'h0E, 8'h00);
    wr(8'h0F, 8'h00);
    wr(8'h10, 8'h01);
    repeat (60) @(posedge clk);
    wr(8'h10, 8'h00);
    rd(8'h0F); chk("period high", 8'h00, d);
    rd(8'h0E); chk("period low bound", 1'b1, d <= 8'h10);
    rd(8'h0C); chk("match, no overflow", 8'h04, d);
    wr(8'h0C, 8'h04);
    wr(8'h22, 8'h08);
    wr(8'h0E, 8'h00);
    wr(8'h10, 8'h01);
    repeat (30) @(posedge clk);
    wr(8'h10, 8'h00);
    rd(8'h0E); chk("no clear outside 1011", 1'b1, d > 8'h10);
    rd(8'h0C); chk("plain match flag", 8'h04, d);
    wr(8'h0C, 8'h04);
    wr(8'h22, 8'h00);
    $display("test compare_clear done");
  endtask : t_compare_clear

  task automatic t_async_sleep;
    wr(8'h0E, 8'hFE);
    wr(8'h0F, 8'hFF);
    wr(8'h10, 8'h07);
    @(posedge clk);
    sleep_mode <= 1'b1;
    pulses(4'h3, 1'b0);
    chk("wake in sleep", 1'b1, wake_req);
    @(posedge clk);
    sleep_mode <= 1'b0;
    wr(8'h10, 8'h00);
    rd(8'h0F);
    h = d;
    rd(8'h0E);
    l = d;
    rd(8'h0F); chk("high reread", h, d);
    chk("async count", 16'h0001, {h, l});
    rd(8'h0C); chk("async overflow", 8'h01, d);
    wr(8'h0C, 8'h01);
    $display("test async_sleep done");
  endtask : t_async_sleep

  task automatic t_osc_input;
    wr(8'h10, 8'h08); chk("osc on", 1'b1, osc_amp_on);
    wr(8'h0E, 8'h00);
    wr(8'h0F, 8'h00);
    wr(8'h10, 8'h0F);
    wr(8'h20, 8'h01);
    wr(8'h22, 8'h0B);
    repeat (20) @(posedge clk);
    pulses(4'h2, 1'b1);
    pulses(4'h1, 1'b0);
    wr(8'h10, 8'h08);
    wr(8'h22, 8'h00);
    rd(8'h0E); chk("osc pin edges", 8'h02, d);
    rd(8'h0C); chk("no async match", 8'h00, d);
    wr(8'h0E, 8'h00);
    wr(8'h10, 8'h1B);
    pulses(4'h4, 1'b1);
    wr(8'h10, 8'h08);
    rd(8'h0E); chk("prescaled edges", 8'h02, d);
    $display("test osc_input done");
  endtask : t_osc_input

  task automatic t_resets;
    wr(8'h10, 8'h38);
    @(posedge clk);
    other_rst <= 1'b1;
    @(posedge clk);
    other_rst <= 1'b0;
    rd(8'h10); chk("control kept", 8'h38, d);
    rd(8'h0E); chk("count kept", 8'h02, d);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(8'h10); chk("control zeroed", 8'h00, d);
    chk("osc off", 1'b0, osc_amp_on);
    rd(8'h0E); chk("count survives", 8'h02, d);
    $display("test resets done");
  endtask : t_resets

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_overflow_irq();
    t_compare_clear();
    t_async_sleep();
    t_osc_input();
    t_resets();
    summarize();
  end
endmodule : tb
`default_nettype wire
